// ### verilog/start_arb_pkg.sv
// constants shared by the start/arbitration engine and its baud counter
// assumes the core steps four internal phases per instruction cycle on the link clock
package start_arb_pkg;

  localparam int unsigned RELOAD_W   = 7;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned PHASE_W    = 2;
  localparam logic [1:0]  PHASE_Q2   = 2'h1;
  localparam logic [1:0]  PHASE_Q4   = 2'h3;
  localparam logic [1:0]  PHASE_LAST = 2'h3;
  localparam logic        PIN_LOW    = 1'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CNT1,
    ST_CNT2,
    ST_ARB_WAIT,
    ST_ARB_HIGH
  } link_state_e;

endpackage : start_arb_pkg

// ### verilog/baud_tick_counter.sv
// down counter that paces bus timing, one step per decrement tick
// assumes load, run and tick come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module baud_tick_counter #(
  parameter int unsigned W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic         run,
  input  wire logic [W-1:0] reload,
  output logic      [W-1:0] count,
  output logic              zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_s;

  cnt_state_s st_q;
  cnt_state_s st_d;

  if (W < 1 || W > 16) begin : g_chk
    $error("baud_tick_counter: width out of range");
  end

  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.cnt = reload;
    end else if (run && tick && st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - W'(1); // stops at zero until reloaded
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count = st_q.cnt;
  assign zero  = (st_q.cnt == '0);

  property p_decrement;
    @(posedge clk) disable iff (!rst_b)
      (!load && run && tick && !zero) |=> (count == $past(count) - W'(1));
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter missed a decrement");

  property p_hold_zero;
    @(posedge clk) disable iff (!rst_b)
      (zero && !load) |=> zero;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter left zero without reload");

endmodule : baud_tick_counter
`default_nettype wire

// ### verilog/start_arb.sv
// start condition generator with start collision checks and scl clock arbitration
// assumes open-drain pins resolved outside; firmware strobes are one-cycle pulses on CLK_SYS
// Operation
// - while scl is released, the baud counter pauses until scl reads high
// - once released scl reads high, reload the counter and count again
// - start with sda or scl already low is a bus collision
// - scl low before sda is driven low during start is a collision
// - on start collision abandon start, set collision flag, reset port to idle
// - start begins with both lines released; load counter and count to zero
// - sda low during first count: reset counter and drive sda low at once
// - sda high through first count: drive sda low at expiry, count again
// - scl low during second count is not a collision
// - second count reaching zero drives scl low, start complete
// - simultaneous starts raise no collision; arbitration continues into address and data
// - counter decrements on second and fourth phases, stops at zero
// - firmware sets start request bit; hardware clears it when sequence ends
`timescale 1ns/1ns
`default_nettype none
module start_arb
  import start_arb_pkg::*;
#(
  parameter int unsigned RELOAD_BITS = start_arb_pkg::RELOAD_W
) (
  input  wire logic                           CLK_SYS,
  input  wire logic                           CLK_LINK,
  input  wire logic                           RST_B,
  input  wire logic                           START_SET,
  input  wire logic                           SCL_RELEASE_REQ,
  input  wire logic                           COLLISION_CLR,
  input  wire logic [start_arb_pkg::REG_W-1:0] BAUD_RELOAD_REG,
  output logic                                START_REQUEST_BIT,
  output logic                                BUS_COLLISION_FLAG,
  output logic                                PORT_IDLE_RESET,
  output logic                                ARB_HIGH_DONE,
  input  wire logic                           SDA_IN,
  output logic                                SDA_OUT,
  output logic                                SDA_OE,
  input  wire logic                           SCL_IN,
  output logic                                SCL_OUT,
  output logic                                SCL_OE
);
  import start_arb_pkg::*;

  if (RELOAD_BITS < 1 || RELOAD_BITS >= REG_W) begin : g_chk
    $error("start_arb: reload width must fit below the reload register width");
  end

  // firmware-side state on CLK_SYS
  typedef struct packed {
    logic                   start_bit;
    logic                   arb_busy;
    logic                   coll_flag;
    logic [RELOAD_BITS-1:0] reload;
    logic                   go_t;
    logic                   rel_t;
    logic                   done_meta;
    logic                   done_sync;
    logic                   done_seen;
    logic                   coll_meta;
    logic                   coll_sync;
    logic                   coll_seen;
    logic                   arb_meta;
    logic                   arb_sync;
    logic                   arb_seen;
    logic                   idle_pulse;
    logic                   arb_pulse;
  } sys_state_s;

  // pin-side state on CLK_LINK
  typedef struct packed {
    link_state_e         state;
    logic [PHASE_W-1:0]  phase;
    logic                sda_meta;
    logic                sda_sync;
    logic                scl_meta;
    logic                scl_sync;
    logic                go_meta;
    logic                go_sync;
    logic                go_seen;
    logic                rel_meta;
    logic                rel_sync;
    logic                rel_seen;
    logic                sda_oe;
    logic                scl_oe;
    logic                done_t;
    logic                coll_t;
    logic                arb_t;
  } link_state_s;

  sys_state_s  sy_q;
  sys_state_s  sy_d;
  link_state_s lk_q;
  link_state_s lk_d;

  logic                   done_ev;
  logic                   coll_ev;
  logic                   arb_ev;
  logic                   req_ok;
  logic                   go_ev;
  logic                   rel_ev;
  logic                   tick;
  logic                   cnt_load;
  logic                   cnt_run;
  logic [RELOAD_BITS-1:0] cnt_val;
  logic                   cnt_zero;

  // event edges read only the second and history stages of each synchroniser
  assign done_ev = sy_q.done_sync ^ sy_q.done_seen;
  assign coll_ev = sy_q.coll_sync ^ sy_q.coll_seen;
  assign arb_ev  = sy_q.arb_sync ^ sy_q.arb_seen;
  // no spooling: a new request is ignored while a sequence is in flight
  assign req_ok  = !sy_q.start_bit && !sy_q.arb_busy;

  always_comb begin
    sy_d            = sy_q;
    sy_d.done_meta  = lk_q.done_t;
    sy_d.done_sync  = sy_q.done_meta;
    sy_d.done_seen  = sy_q.done_sync;
    sy_d.coll_meta  = lk_q.coll_t;
    sy_d.coll_sync  = sy_q.coll_meta;
    sy_d.coll_seen  = sy_q.coll_sync;
    sy_d.arb_meta   = lk_q.arb_t;
    sy_d.arb_sync   = sy_q.arb_meta;
    sy_d.arb_seen   = sy_q.arb_sync;
    sy_d.idle_pulse = coll_ev;
    sy_d.arb_pulse  = arb_ev;
    if (req_ok && START_SET) begin
      // reload is frozen here so the link side reads a stable word
      sy_d.reload    = BAUD_RELOAD_REG[RELOAD_BITS-1:0];
      sy_d.start_bit = 1'b1;
      sy_d.go_t      = !sy_q.go_t;
    end else if (req_ok && SCL_RELEASE_REQ) begin
      sy_d.reload   = BAUD_RELOAD_REG[RELOAD_BITS-1:0];
      sy_d.arb_busy = 1'b1;
      sy_d.rel_t    = !sy_q.rel_t;
    end
    if (done_ev || coll_ev) begin
      sy_d.start_bit = 1'b0;
    end
    if (arb_ev) begin
      sy_d.arb_busy = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (COLLISION_CLR) begin
      sy_d.coll_flag = 1'b0;
    end
    if (coll_ev) begin
      sy_d.coll_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign START_REQUEST_BIT  = sy_q.start_bit;
  assign BUS_COLLISION_FLAG = sy_q.coll_flag;
  assign PORT_IDLE_RESET    = sy_q.idle_pulse;
  assign ARB_HIGH_DONE      = sy_q.arb_pulse;

  assign go_ev  = lk_q.go_sync ^ lk_q.go_seen;
  assign rel_ev = lk_q.rel_sync ^ lk_q.rel_seen;
  assign tick   = (lk_q.phase == PHASE_Q2) || (lk_q.phase == PHASE_Q4);

  baud_tick_counter #(
    .W      (RELOAD_BITS)
  ) u_baud_tick_counter (
    .clk    (CLK_LINK),
    .rst_b  (RST_B),
    .tick   (tick),
    .load   (cnt_load),
    .run    (cnt_run),
    .reload (sy_q.reload),
    .count  (cnt_val),
    .zero   (cnt_zero)
  );

  always_comb begin
    lk_d          = lk_q;
    cnt_load      = 1'b0;
    cnt_run       = 1'b0;
    lk_d.phase    = (lk_q.phase == PHASE_LAST) ? '0 : lk_q.phase + PHASE_W'(1);
    lk_d.sda_meta = SDA_IN;
    lk_d.sda_sync = lk_q.sda_meta;
    lk_d.scl_meta = SCL_IN;
    lk_d.scl_sync = lk_q.scl_meta;
    lk_d.go_meta  = sy_q.go_t;
    lk_d.go_sync  = lk_q.go_meta;
    lk_d.go_seen  = lk_q.go_sync;
    lk_d.rel_meta = sy_q.rel_t;
    lk_d.rel_sync = lk_q.rel_meta;
    lk_d.rel_seen = lk_q.rel_sync;
    unique case (lk_q.state)
      ST_IDLE: begin
        if (go_ev) begin
          if (lk_q.sda_sync == PIN_LOW || lk_q.scl_sync == PIN_LOW) begin
            lk_d.coll_t = !lk_q.coll_t;
            lk_d.sda_oe = 1'b0;
            lk_d.scl_oe = 1'b0;
          end else begin
            lk_d.sda_oe = 1'b0;
            lk_d.scl_oe = 1'b0;
            cnt_load    = 1'b1;
            lk_d.state  = ST_CNT1;
          end
        end else if (rel_ev) begin
          lk_d.scl_oe = 1'b0;
          lk_d.state  = ST_ARB_WAIT;
        end
      end
      ST_CNT1: begin
        cnt_run = 1'b1;
        if (lk_q.scl_sync == PIN_LOW) begin
          // another master is presumed to be sending a one
          lk_d.coll_t = !lk_q.coll_t;
          lk_d.state  = ST_IDLE;
        end else if (lk_q.sda_sync == PIN_LOW) begin
          lk_d.sda_oe = 1'b1;
          cnt_load    = 1'b1;
          lk_d.state  = ST_CNT2;
        end else if (cnt_zero) begin
          lk_d.sda_oe = 1'b1;
          cnt_load    = 1'b1;
          lk_d.state  = ST_CNT2;
        end
      end
      ST_CNT2: begin
        // scl low here is left alone so the address phase can arbitrate
        cnt_run = 1'b1;
        if (cnt_zero) begin
          lk_d.scl_oe = 1'b1;
          lk_d.done_t = !lk_q.done_t;
          lk_d.state  = ST_IDLE;
        end
      end
      ST_ARB_WAIT: begin
        // a slave stretching scl freezes the count here
        if (lk_q.scl_sync != PIN_LOW) begin
          cnt_load   = 1'b1;
          lk_d.state = ST_ARB_HIGH;
        end
      end
      ST_ARB_HIGH: begin
        cnt_run = 1'b1;
        if (cnt_zero) begin
          lk_d.scl_oe = 1'b1;
          lk_d.arb_t  = !lk_q.arb_t;
          lk_d.state  = ST_IDLE;
        end
      end
      default: begin
        lk_d.state  = ST_IDLE;
        lk_d.sda_oe = 1'b0;
        lk_d.scl_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_LINK or negedge RST_B) begin
    if (!RST_B) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // open drain: the pin only ever drives low
  assign SDA_OUT = PIN_LOW;
  assign SCL_OUT = PIN_LOW;
  assign SDA_OE  = lk_q.sda_oe;
  assign SCL_OE  = lk_q.scl_oe;

  property p_arb_pause;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_ARB_WAIT && lk_q.scl_sync == PIN_LOW)
        |=> (lk_q.state == ST_ARB_WAIT && !lk_q.scl_oe);
  endproperty
  a_arb_pause: assert property (p_arb_pause) else $error("counter ran while scl held low");

  property p_arb_reload;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_ARB_WAIT && lk_q.scl_sync != PIN_LOW)
        |=> (lk_q.state == ST_ARB_HIGH && cnt_val == sy_q.reload);
  endproperty
  a_arb_reload: assert property (p_arb_reload) else $error("no reload on scl high");

  property p_start_busy_line;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_IDLE && go_ev && (lk_q.sda_sync == PIN_LOW || lk_q.scl_sync == PIN_LOW))
        |=> ($changed(lk_q.coll_t) && lk_q.state == ST_IDLE && !lk_q.sda_oe);
  endproperty
  a_start_busy_line: assert property (p_start_busy_line) else $error("busy line not flagged");

  property p_scl_early;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_CNT1 && lk_q.scl_sync == PIN_LOW)
        |=> ($changed(lk_q.coll_t) && lk_q.state == ST_IDLE && !lk_q.sda_oe);
  endproperty
  a_scl_early: assert property (p_scl_early) else $error("scl low in first count not flagged");

  property p_coll_flag;
    @(posedge CLK_SYS) disable iff (!RST_B)
      coll_ev |=> (sy_q.coll_flag && !sy_q.start_bit && sy_q.idle_pulse);
  endproperty
  a_coll_flag: assert property (p_coll_flag) else $error("collision not reported");

  property p_sda_early;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_CNT1 && lk_q.scl_sync != PIN_LOW && lk_q.sda_sync == PIN_LOW)
        |=> (lk_q.sda_oe && lk_q.state == ST_CNT2 && cnt_val == sy_q.reload);
  endproperty
  a_sda_early: assert property (p_sda_early) else $error("sda not asserted early");

  property p_sda_expiry;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_CNT1 && lk_q.scl_sync != PIN_LOW && lk_q.sda_sync != PIN_LOW && cnt_zero)
        |=> (lk_q.sda_oe && lk_q.state == ST_CNT2 && !lk_q.scl_oe);
  endproperty
  a_sda_expiry: assert property (p_sda_expiry) else $error("sda not driven at first expiry");

  property p_no_coll_cnt2;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_CNT2 && lk_q.scl_sync == PIN_LOW) |=> !$changed(lk_q.coll_t);
  endproperty
  a_no_coll_cnt2: assert property (p_no_coll_cnt2) else $error("false collision in second count");

  property p_scl_low_end;
    @(posedge CLK_LINK) disable iff (!RST_B)
      (lk_q.state == ST_CNT2 && cnt_zero)
        |=> (lk_q.scl_oe && lk_q.sda_oe && lk_q.state == ST_IDLE && $changed(lk_q.done_t));
  endproperty
  a_scl_low_end: assert property (p_scl_low_end) else $error("start not completed");

  property p_start_clear;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (done_ev && !coll_ev) |=> (!sy_q.start_bit ##1 !sy_q.start_bit);
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");

endmodule : start_arb
`default_nettype wire

// ### tb/bus_peer.sv
// other masters and slaves on the open-drain bus, seen as pull-downs on sda and scl
// assumes the bench resolves each wire as pulled up unless some party pulls it low
`timescale 1ns/1ns
`default_nettype none
module bus_peer (
  input  wire logic       clk_link,
  input  wire logic       rst_b,
  input  wire logic       scl_oe,
  input  wire logic       force_sda_low,
  input  wire logic       force_scl_low,
  input  wire logic [7:0] stretch,
  output logic            sda_pull,
  output logic            scl_pull
);
  logic [7:0] cnt_q;
  logic       scl_oe_q;

  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= 8'h00;
      scl_oe_q <= 1'h0;
    end else begin
      scl_oe_q <= scl_oe;
      if (scl_oe_q && !scl_oe) begin
        cnt_q <= stretch;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  assign sda_pull = force_sda_low;
  // picks up the low at once when the master lets go, so no high glitch leaks before the stretch
  assign scl_pull = force_scl_low | (cnt_q != 8'h00) | (scl_oe_q & ~scl_oe);
endmodule : bus_peer
`default_nettype wire

// ### tb/i2c_master_start_and_clock_arbitration_tb_top.sv
// self-checking bench for the start generator and scl clock arbitration
// assumes the design package is compiled first and bus_peer stands for the far side
`timescale 1ns/1ns
`default_nettype none
module i2c_master_start_and_clock_arbitration_tb_top;
  import start_arb_pkg::*;
  logic             clk_sys    = 1'h0;
  logic             clk_link   = 1'h1;
  logic             rst_b      = 1'h0;
  logic             start_set  = 1'h0;
  logic             rel_req    = 1'h0;
  logic             coll_clr   = 1'h0;
  logic [REG_W-1:0] reload_reg = 8'h00;
  logic             f_sda      = 1'h0;
  logic             f_scl      = 1'h0;
  logic [7:0]       stretch    = 8'h00;
  logic             sbit, cflag, idle_p, arb_done, sda_o, sda_oe, scl_o, scl_oe, sda_pull, scl_pull;
  logic             sda_oe_p, scl_oe_p, seen_idle, seen_done;
  int               err_total, cmp_count, lcnt, t_sda, t_scl, t_off, cyc;
  logic             exp_coll[$];
  wire logic        sda_w = !(sda_oe | sda_pull);
  wire logic        scl_w = !(scl_oe | scl_pull);

  always #4 clk_sys = ~clk_sys;
  // starts high so no rising link edge lands on a stimulus instant
  always #3 clk_link = ~clk_link;

  start_arb DUT (.CLK_SYS(clk_sys), .CLK_LINK(clk_link), .RST_B(rst_b), .START_SET(start_set),
    .SCL_RELEASE_REQ(rel_req), .COLLISION_CLR(coll_clr), .BAUD_RELOAD_REG(reload_reg),
    .START_REQUEST_BIT(sbit), .BUS_COLLISION_FLAG(cflag), .PORT_IDLE_RESET(idle_p),
    .ARB_HIGH_DONE(arb_done), .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE(sda_oe), .SCL_IN(scl_w),
    .SCL_OUT(scl_o), .SCL_OE(scl_oe));

  bus_peer peer (.clk_link(clk_link), .rst_b(rst_b), .scl_oe(scl_oe), .force_sda_low(f_sda),
    .force_scl_low(f_scl), .stretch(stretch), .sda_pull(sda_pull), .scl_pull(scl_pull));

  // link-cycle timestamps of the pin enables; edges are seen before the design's updates land
  always @(posedge clk_link) begin
    lcnt = lcnt + 1;
    if (sda_oe === 1'h1 && sda_oe_p === 1'h0) t_sda = lcnt;
    if (scl_oe === 1'h1 && scl_oe_p === 1'h0) t_scl = lcnt;
    if (scl_oe === 1'h0 && scl_oe_p === 1'h1) t_off = lcnt;
    sda_oe_p = sda_oe;
    scl_oe_p = scl_oe;
  end

  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (idle_p === 1'h1) seen_idle = 1'h1;
    if (arb_done === 1'h1) seen_done = 1'h1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk_bit(input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_bit

  task automatic chk_range(input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h..%h got=%h", $time, lo, hi, got);
    end
  endtask : chk_range

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic do_reset;
    rst_b = 1'h0;
    f_sda = 1'h0;
    f_scl = 1'h0;
    tick(16);
    chk_bit(1'h0, scl_oe);
    chk_bit(1'h0, sda_oe);
    rst_b = 1'h1;
    tick(4);
  endtask : do_reset

  // act: 0 clean, 1 sda low at start, 2 scl low at start, 3 scl low in first count,
  // 4 sda low in first count, 5 scl low in second count
  task automatic run_start(input int act, input int r);
    int   t_req, k;
    logic coll;
    // model: a line already low, or scl low in the first count, means collision
    exp_coll.push_back(act >= 1 && act <= 3);
    // bit 7 set on purpose: only the low seven bits may reach the counter
    reload_reg = {1'h1, r[6:0]};
    f_sda = (act == 1);
    f_scl = (act == 2);
    tick(4);
    seen_idle = 1'h0;
    start_set = 1'h1;
    t_req = lcnt;
    tick(1);
    chk_bit(1'h1, sbit);
    k = 0;
    while (sbit === 1'h1 && k < 2000) begin
      start_set = (k == 2);
      if (k == 8 && act == 3) f_scl = 1'h1;
      if (k == 8 && act == 4) f_sda = 1'h1;
      if (act == 5 && sda_oe === 1'h1) f_scl = 1'h1;
      tick(1);
      k++;
    end
    start_set = 1'h0;
    chk_bit(1'h0, sbit);
    tick(3);
    coll = exp_coll.pop_front();
    chk_bit(coll, cflag);
    chk_bit(coll, seen_idle);
    chk_bit(!coll, sda_oe);
    chk_bit(!coll, scl_oe);
    chk_bit(1'h0, sda_o | scl_o);
    if (!coll) begin
      if (act == 4) chk_range(0, 2 * r - 1, t_sda - t_req);
      else chk_range(2 * r - 4, 2 * r + 12, t_sda - t_req);
      chk_range(2 * r - 4, 2 * r + 4, t_scl - t_sda);
    end
    f_sda = 1'h0;
    f_scl = 1'h0;
  endtask : run_start

  task automatic run_release(input int r, input int s);
    int k;
    stretch = s[7:0];
    reload_reg = {1'h0, r[6:0]};
    seen_done = 1'h0;
    rel_req = 1'h1;
    tick(1);
    rel_req = 1'h0;
    k = 0;
    while (seen_done !== 1'h1 && k < 2000) begin
      tick(1);
      k++;
    end
    chk_bit(1'h1, seen_done);
    chk_bit(1'h1, scl_oe);
    // counter must hold through the stretch, then give a full count of high time
    chk_range(s + 2 * r - 4, s + 2 * r + 14, t_scl - t_off);
  endtask : run_release

  initial begin
    void'($urandom(35452));
    for (int a = 0; a < 6; a++) begin
      do_reset();
      run_start(a, 12 + $urandom_range(15));
      if (a >= 1 && a <= 3) begin
        coll_clr = 1'h1;
        tick(1);
        coll_clr = 1'h0;
        tick(1);
        chk_bit(1'h0, cflag);
      end else begin
        run_release(1 + $urandom_range(20), 5 + $urandom_range(25));
        run_release(1 + $urandom_range(20), $urandom_range(3));
      end
    end
    report_and_stop();
  end
endmodule : i2c_master_start_and_clock_arbitration_tb_top
`default_nettype wire
